/* File: inc/console_pkg.sv */
/*
 * Constants for the serial console command interpreter: register map, field layouts,
 * reset values, command codes and timing counts.
 * Assumes a 100 MHz clock and a byte-level UART outside this block.
 */
package console_pkg;

    // Clock and timing.
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          QUIET_TIME_MS     = 1000;
    localparam longint      QUIET_CYCLES      = longint'(CLK_HZ) / 1000 * QUIET_TIME_MS;

    // Register byte offsets.
    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_SETTINGS     = 8'h04;
    localparam logic [7:0]  ADDR_STATUS       = 8'h08;
    localparam logic [7:0]  ADDR_AUDIO        = 8'h0C;

    // Field positions of the settings register.
    localparam int          FLD_VOL_LSB       = 0;
    localparam int          FLD_FILT_LSB      = 8;
    localparam int          FLD_XFEED_LSB     = 12;
    localparam int          FLD_PHASE_BIT     = 16;
    localparam int          FLD_PAR_BIT       = 17;
    localparam int          FLD_VFIX_BIT      = 18;
    localparam int          FLD_BAUD_LSB      = 20;
    localparam int          FLD_SVOL_LSB      = 24;

    // Reset values and filter codes.
    localparam logic [7:0]  VOL_RESET         = 8'h00;
    localparam logic [2:0]  FILT_MIXED        = 3'h5;
    localparam logic [2:0]  FILT_LINEAR       = 3'h4;
    localparam logic [2:0]  FILT_MINIMUM      = 3'h6;
    localparam logic [2:0]  FILT_SOFT         = 3'h7;
    localparam logic [2:0]  BAUD_115200       = 3'h4;

    // Input select codes.
    localparam logic [2:0]  IN_AUTO           = 3'h7;
    localparam logic [2:0]  IN_USB            = 3'h0;
    localparam logic [2:0]  IN_SPDIF_MAX      = 3'h5;

    // Volume limits in dB, two's complement.
    localparam logic signed [7:0] VOL_MIN     = -8'sd90;
    localparam logic signed [7:0] VOL_MAX     = 8'sd10;
    localparam logic signed [7:0] SVOL_MIN    = -8'sd80;

    // Characters.
    localparam logic [7:0]  CH_PLUS           = 8'h2B;
    localparam logic [7:0]  CH_HASH           = 8'h23;
    localparam logic [7:0]  CH_CR             = 8'h0D;
    localparam logic [7:0]  CH_QMARK          = 8'h3F;
    localparam logic [7:0]  CH_ACK            = 8'h06;

    // Monitor command codes written to the control register.
    typedef enum logic [3:0] {
        CMD_NONE, CMD_HELP, CMD_SET, CMD_SHOW, CMD_DOWNLOAD, CMD_UPDATE, CMD_EXIT
    } mon_cmd_t;

endpackage

/* File: rtl/console_interp.sv */
/*
 * Serial console command interpreter: byte stream in, status and prompt bytes out,
 * run mode and configuration monitor, settings registers, input autoselect.
 * Assumes a byte UART outside that presents received bytes as one-cycle strobes and
 * accepts transmit bytes by valid/ready; software parses text lines and reaches the
 * settings over AXI4-Lite.
 */
module console_interp
    import console_pkg::*;
#(
    parameter longint QUIET_COUNT = QUIET_CYCLES
)(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // Received byte stream
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    // Transmit byte stream
    output logic             tx_valid_o,
    output logic [7:0]       tx_byte_o,
    input  wire logic        tx_ready_i,
    // Audio side
    input  wire logic        spdif_valid_i,
    input  wire logic [2:0]  spdif_port_i,
    input  wire logic        usb_active_i,
    input  wire logic        phones_sel_i,
    input  wire logic [23:0] link_speed_i,
    output logic [2:0]       input_active_o,
    output logic [7:0]       volume_o,
    output logic [2:0]       filter_o,
    output logic [1:0]       xfeed_o,
    output logic             invert_o,
    output logic             parallel_o,
    output logic [2:0]       baud_sel_o,
    output logic             xmodem_o,
    output logic             monitor_o,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {ST_RUN, ST_MONITOR, ST_XFER} mode_t;

    typedef struct packed {
        mode_t        mode;
        logic [1:0]   plus_cnt;
        logic [31:0]  quiet_cnt;
        logic         armed;
        logic         tx_pend;
        logic [7:0]   tx_byte;
        logic         line_done;
        logic [7:0]   last_byte;
        logic signed [7:0] vol;
        logic signed [7:0] svol;
        logic         vfix;
        logic [2:0]   filt;
        logic [1:0]   xfeed;
        logic         invert;
        logic         parallel;
        logic [2:0]   baud;
        logic [2:0]   in_sel;
        logic [2:0]   in_act;
        logic         upd_req;
        logic         aw_got;
        logic         w_got;
        logic [7:0]   aw_addr;
        logic [31:0]  w_data;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } state_t;

    state_t q, d;

    function automatic logic signed [7:0] clamp(input logic signed [7:0] v,
                                                input logic signed [7:0] lo);
        clamp = (v < lo) ? lo : (v > VOL_MAX) ? VOL_MAX : v;
    endfunction

    logic       wr_fire;
    logic       prompt_req;
    logic [3:0] cmd;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        d          = q;
        wr_fire    = q.aw_got && q.w_got && !q.bvalid;
        cmd        = wr_fire ? q.w_data[3:0] : 4'h0;
        prompt_req = 1'b0;

        // The transmit slot holds the last byte loaded, CH_HASH or CH_ACK, until tx_ready_i takes it.
        if (q.tx_pend && tx_ready_i)
        begin
            d.tx_pend = 1'b0;
        end

        // Escape detection: count pluses, then require a full quiet second.
        if (q.mode == ST_RUN)
        begin
            if (rx_valid_i)
            begin
                d.quiet_cnt = 32'h0000_0000;
                d.armed     = 1'b0;
                // Extra pluses hold the count at three, so the last three before the pause decide.
                if (rx_byte_i == CH_PLUS)
                begin
                    d.plus_cnt = (q.plus_cnt == 2'd3) ? 2'd3 : q.plus_cnt + 2'd1;
                    d.armed    = (q.plus_cnt >= 2'd2);
                end
                else
                begin
                    d.plus_cnt = 2'd0;
                end
            end
            else if (q.armed)
            begin
                d.quiet_cnt = q.quiet_cnt + 32'h0000_0001;
                if (q.quiet_cnt == 32'(QUIET_COUNT - 1))
                begin
                    d.mode      = ST_MONITOR;
                    d.armed     = 1'b0;
                    d.plus_cnt  = 2'd0;
                    prompt_req  = 1'b1;
                end
            end
        end

        // Each carriage return flags a finished line for the line parser in software.
        if (rx_valid_i)
        begin
            d.last_byte = rx_byte_i;
            if (rx_byte_i == CH_CR)
            begin
                d.line_done = 1'b1;
            end
        end

        // Control register commands from the line parser.
        if (wr_fire && q.aw_addr == ADDR_CTRL)
        begin
            d.line_done = rx_valid_i && rx_byte_i == CH_CR;
            case (cmd)
                CMD_EXIT:
                begin
                    d.mode = ST_RUN;
                end
                CMD_DOWNLOAD:
                begin
                    if (q.mode == ST_MONITOR)
                    begin
                        d.mode = ST_XFER;
                    end
                end
                CMD_UPDATE:
                begin
                    d.upd_req = (q.mode == ST_MONITOR);
                end
                CMD_HELP, CMD_SHOW, CMD_SET:
                begin
                    prompt_req = q.mode == ST_MONITOR;
                end
                default:
                begin
                    d.mode = q.mode;
                end
            endcase
            if (q.w_data[4] && q.mode == ST_XFER)
            begin
                d.mode     = ST_MONITOR;
                prompt_req = 1'b1;
            end
        end

        // Settings writes: out-of-range filter and baud values leave the setting untouched; volumes are clamped.
        if (wr_fire && q.aw_addr == ADDR_SETTINGS)
        begin
            if (q.wstrb[0])
            begin
                d.vol = clamp(q.w_data[FLD_VOL_LSB +: 8], VOL_MIN);
            end
            if (q.wstrb[1] && q.w_data[FLD_FILT_LSB +: 3] >= FILT_LINEAR)
            begin
                d.filt = q.w_data[FLD_FILT_LSB +: 3];
            end
            if (q.wstrb[1])
            begin
                d.xfeed = q.w_data[FLD_XFEED_LSB +: 2];
            end
            if (q.wstrb[2])
            begin
                d.invert   = q.w_data[FLD_PHASE_BIT];
                d.parallel = q.w_data[FLD_PAR_BIT];
                d.vfix     = q.w_data[FLD_VFIX_BIT];
                if (q.w_data[FLD_BAUD_LSB +: 3] <= BAUD_115200)
                begin
                    d.baud = q.w_data[FLD_BAUD_LSB +: 3];
                end
            end
            if (q.wstrb[3])
            begin
                d.svol = clamp(q.w_data[FLD_SVOL_LSB +: 8], SVOL_MIN);
            end
            if (q.mode == ST_RUN)
            begin
                d.tx_pend = 1'b1;
                d.tx_byte = CH_ACK;
            end
        end
        if (wr_fire && q.aw_addr == ADDR_AUDIO)
        begin
            if (q.w_data[2:0] == IN_AUTO || q.w_data[2:0] <= IN_SPDIF_MAX)
            begin
                d.in_sel = q.w_data[2:0];
            end
        end

        if (prompt_req)
        begin
            d.tx_pend = 1'b1;
            d.tx_byte = CH_HASH;
        end

        // Autoselect: a valid coax/optical stream wins over USB.
        if (q.in_sel == IN_AUTO)
        begin
            d.in_act = spdif_valid_i ? spdif_port_i : (usb_active_i ? IN_USB : q.in_act);
        end
        else
        begin
            d.in_act = q.in_sel;
        end

        // AXI4-Lite write channel.
        if (s_axi_awvalid && !q.aw_got)
        begin
            d.aw_got  = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_got)
        begin
            d.w_got  = 1'b1;
            d.w_data = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (wr_fire)
        begin
            d.bvalid = 1'b1;
            d.bresp  = (q.aw_addr[7:4] == 4'h0 && q.aw_addr[1:0] == 2'b00 && q.aw_addr != ADDR_STATUS)
                       ? 2'b00 : 2'b10;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
        end

        // AXI4-Lite read channel.
        if (s_axi_arvalid && !q.rvalid)
        begin
            d.rvalid = 1'b1;
            d.rresp  = 2'b00;
            case (s_axi_araddr)
                ADDR_CTRL:     d.rdata = {20'h0_0000, q.last_byte, q.upd_req, q.line_done,
                                          q.mode == ST_XFER, q.mode != ST_RUN};
                ADDR_SETTINGS: d.rdata = {q.svol, 1'b0, q.baud, 1'b0, q.vfix, q.parallel, q.invert,
                                          2'b00, q.xfeed, 1'b0, q.filt, q.vol};
                ADDR_STATUS:   d.rdata = {5'h00, q.in_act, link_speed_i};
                ADDR_AUDIO:    d.rdata = {29'h0000_0000, q.in_sel};
                default:
                begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = 2'b10;
                end
            endcase
        end
        else if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            q          <= '0;
            q.mode     <= ST_RUN;
            q.vol      <= VOL_RESET;
            q.svol     <= VOL_RESET;
            q.filt     <= FILT_MIXED;
            q.baud     <= BAUD_115200;
            q.in_sel   <= IN_AUTO;
            q.in_act   <= IN_USB;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready  = !q.aw_got;
    assign s_axi_wready   = !q.w_got;
    assign s_axi_bvalid   = q.bvalid;
    assign s_axi_bresp    = q.bresp;
    assign s_axi_arready  = !q.rvalid;
    assign s_axi_rvalid   = q.rvalid;
    assign s_axi_rdata    = q.rdata;
    assign s_axi_rresp    = q.rresp;
    assign tx_valid_o     = q.tx_pend;
    assign tx_byte_o      = q.tx_byte;
    assign input_active_o = q.in_act;
    assign volume_o       = q.vol;
    assign filter_o       = q.filt;
    assign xfeed_o        = phones_sel_i ? q.xfeed : 2'b00;
    assign invert_o       = q.invert;
    assign parallel_o     = q.parallel;
    assign baud_sel_o     = q.baud;
    assign xmodem_o       = q.mode == ST_XFER;
    assign monitor_o      = q.mode != ST_RUN;

    ////////////////////////////////////////////////////////////////////////////////
    a_run_after_reset: assert property (@(posedge ref_clk_i) (!sys_rst_i && $past(sys_rst_i)) |-> !monitor_o)
        else $error("not in run mode after reset");
    a_prompt_on_entry: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (!monitor_o ##1 monitor_o) |-> tx_valid_o && tx_byte_o == CH_HASH)
        else $error("no prompt on monitor entry");
    a_volume_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $signed(volume_o) >= VOL_MIN && $signed(volume_o) <= VOL_MAX)
        else $error("volume out of range");
    a_filter_codes: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        filter_o >= FILT_LINEAR)
        else $error("bad filter code");
    a_baud_legal: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        baud_sel_o <= BAUD_115200)
        else $error("illegal baud select");
    a_xfeed_phones: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !phones_sel_i |-> xfeed_o == 2'b00)
        else $error("crossfeed without headphones");
    a_spdif_priority: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (q.in_sel == IN_AUTO && spdif_valid_i) |=> input_active_o == $past(spdif_port_i))
        else $error("spdif not preferred");
    a_escape_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        (rx_valid_i && !monitor_o) |=> !monitor_o)
        else $error("monitor entered without quiet time");

endmodule

/* File: sim/host_terminal.sv */
/*
 * Host terminal model for the far side of the console byte link.
 * Assumes the block takes received bytes as one-cycle strobes and offers transmit bytes by valid/ready.
 */
module host_terminal
(
    // Clock
    input  wire logic       ref_clk_i,
    // Bytes sent by the block
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_byte_i,
    output logic            tx_ready_o,
    input  wire logic       slow_i,
    // Bytes sent to the block
    output logic            rx_valid_o,
    output logic [7:0]      rx_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    logic [1:0] phase_q = 2'h0;
    initial
    begin
        tx_ready_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // A slow terminal takes one byte in four cycles, so the block must hold each byte.
    always @(posedge ref_clk_i)
    begin
        if (tx_valid_i && tx_ready_o)
            got_q.push_back(tx_byte_i);
        phase_q <= phase_q + 2'h1;
        tx_ready_o <= !slow_i || (phase_q == 2'h3);
    end
    // Outside a strobe the byte lines carry the inverse, so stale data is never mistaken for new.
    task automatic send_byte(input logic [7:0] b);
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge ref_clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~b;
        repeat (2) @(posedge ref_clk_i);
    endtask
endmodule

/* File: sim/serial_console_control_interpreter_test.sv */
/*
 * Self-checking bench for the console interpreter: escape, monitor commands, settings,
 * autoselect and error responses, with random settings among hand-picked corners.
 * Assumes host_terminal.sv and the console package.
 */
module serial_console_control_interpreter_test
    import console_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QUIET = 50;
    logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, slow = 1'b0;
    logic        rx_valid_i, tx_valid_o, tx_ready_i, monitor_o, xmodem_o, invert_o, parallel_o;
    logic [7:0]  rx_byte_i, tx_byte_o, volume_o;
    logic [2:0]  input_active_o, filter_o, baud_sel_o;
    logic [1:0]  xfeed_o, s_axi_bresp, s_axi_rresp, r;
    logic        spdif_valid_i = 1'b0, usb_active_i = 1'b1, phones_sel_i = 1'b0;
    logic [2:0]  spdif_port_i = 3'h1, p;
    logic [23:0] link_speed_i = 24'h30_3030;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, e_vol = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d, w, seed = 32'h0000_AD0D;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [2:0]  e_filt = FILT_MIXED, e_baud = BAUD_115200;
    int          fail_count = 0, total_checks = 0, cycles = 0, v;
    mon_cmd_t    cmds[3] = '{CMD_HELP, CMD_SHOW, CMD_SET};

    console_interp #(.QUIET_COUNT(QUIET)) DUT (
        .ref_clk_i, .sys_rst_i, .rx_valid_i, .rx_byte_i, .tx_valid_o, .tx_byte_o, .tx_ready_i,
        .spdif_valid_i, .spdif_port_i, .usb_active_i, .phones_sel_i, .link_speed_i, .input_active_o,
        .volume_o, .filter_o, .xfeed_o, .invert_o, .parallel_o, .baud_sel_o, .xmodem_o, .monitor_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    host_terminal host (.ref_clk_i, .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
        .tx_ready_o(tx_ready_i), .slow_i(slow), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));

    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] clamp(input int x);
        return 8'(x < -90 ? -90 : (x > 10 ? 10 : x));
    endfunction
    task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] x);
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= x;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge ref_clk_i);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic expect_tx(input string name, input logic [7:0] e);
        for (int n = 0; n < 300 && host.got_q.size() == 0; n++)
            @(posedge ref_clk_i);
        check(name, e, host.got_q.size() ? host.got_q.pop_front() : 8'hXX);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        tick(2);
        check("volume_o", 0, volume_o);
        check("filter_o", FILT_MIXED, filter_o);
        check("baud_sel_o", BAUD_115200, baud_sel_o);
        check("monitor_o", 0, monitor_o);
        check("invert_o", 0, invert_o);
        check("input_active_o", IN_USB, input_active_o);
        $display("test reset ended");
        host.send_byte(CH_PLUS);
        host.send_byte(CH_PLUS);
        tick(QUIET + 10);
        check("monitor_o", 0, monitor_o);
        host.got_q.delete();
        repeat (3) host.send_byte(CH_PLUS);
        tick(QUIET - 10);
        check("monitor_o", 0, monitor_o);
        for (v = 0; v < 40 && monitor_o !== 1'b1; v++)
            tick(1);
        check("monitor_o", 1, monitor_o);
        expect_tx("prompt", CH_HASH);
        $display("test escape ended");
        foreach (cmds[i])
        begin
            host.got_q.delete();
            axi_write(ADDR_CTRL, {28'h000_0000, cmds[i]});
            expect_tx("prompt", CH_HASH);
        end
        axi_write(ADDR_CTRL, {28'h000_0000, CMD_DOWNLOAD});
        tick(2);
        check("xmodem_o", 1, xmodem_o);
        axi_write(ADDR_CTRL, 32'h0000_0010);
        tick(2);
        check("xmodem_o", 0, xmodem_o);
        axi_write(ADDR_CTRL, {28'h000_0000, CMD_UPDATE});
        host.send_byte(8'h41);
        host.send_byte(CH_CR);
        axi_read(ADDR_CTRL);
        check("line_done", {1'b1, CH_CR}, {d[2], d[11:4]});
        check("update_req", 1, d[3]);
        axi_write(ADDR_CTRL, {28'h000_0000, CMD_EXIT});
        tick(2);
        check("monitor_o", 0, monitor_o);
        sys_rst_i <= 1'b1;
        tick(3);
        sys_rst_i <= 1'b0;
        tick(2);
        axi_read(ADDR_CTRL);
        check("update_req", 0, d[3]);
        check("monitor_o", 0, monitor_o);
        $display("test monitor ended");
        slow <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            w = rnd();
            v = (i == 0) ? -91 : (i == 1) ? 11 : int'(w % 121) - 105;
            if (i == 0)
                w[5:0] = 6'h2B;
            phones_sel_i <= w[10];
            e_vol = clamp(v);
            if (w[2:0] >= FILT_LINEAR)
                e_filt = w[2:0];
            if (w[5:3] <= BAUD_115200)
                e_baud = w[5:3];
            host.got_q.delete();
            axi_write(ADDR_SETTINGS, {9'h000, w[5:3], 2'h0, w[9:8], 2'h0, w[7:6], 1'b0, w[2:0], v[7:0]});
            check("bresp", 0, r);
            expect_tx("ack", CH_ACK);
            tick(2);
            check("volume_o", e_vol, volume_o);
            check("filter_o", e_filt, filter_o);
            check("baud_sel_o", e_baud, baud_sel_o);
            check("xfeed_o", w[10] ? w[7:6] : 2'h0, xfeed_o);
            check("mode_phase", w[9:8], {parallel_o, invert_o});
        end
        slow <= 1'b0;
        s_axi_wstrb <= 4'hC;
        axi_write(ADDR_SETTINGS, {8'hAF, 1'b0, e_baud, 2'h1, w[9:8], 16'hFFFF});
        s_axi_wstrb <= 4'hF;
        axi_read(ADDR_SETTINGS);
        check("settings_hi", {8'hB0, 1'b0, e_baud, 2'h1, w[9:8]}, d[31:16]);
        check("volume_o", e_vol, volume_o);
        check("filter_o", e_filt, filter_o);
        $display("test settings ended");
        axi_write(ADDR_STATUS, 32'hFFFF_FFFF);
        check("bresp", 2'h2, r);
        axi_read(8'h10);
        check("rresp", 2'h2, r);
        check("rdata", 0, d);
        tick(2);
        check("volume_o", e_vol, volume_o);
        $display("test errors ended");
        for (int i = 0; i < 6; i++)
        begin
            w = rnd();
            p = 3'h1 + {1'b0, w[2:1]};
            spdif_valid_i <= ~i[0];
            spdif_port_i <= p;
            link_speed_i <= w[31:8];
            tick(3);
            axi_read(ADDR_STATUS);
            check("input_active_o", i[0] ? IN_USB : p, input_active_o);
            check("status", {i[0] ? IN_USB : p, w[31:8]}, d[26:0]);
        end
        for (int c = 0; c <= 6; c++)
        begin
            axi_write(ADDR_AUDIO, c);
            tick(2);
            check("input_active_o", (c == 6) ? 5 : c, input_active_o);
        end
        axi_write(ADDR_AUDIO, {29'h0000_0000, IN_AUTO});
        $display("test inputs ended");
        end_of_test();
    end
endmodule
